// File: rtl/oam_alu.sv
// Result and zero-detect datapath shared by the four instructions
`timescale 1ns/1ns
module oam_alu #(
   parameter int DATA_W = 8
)(
   input wire oam_pkg::oam_alu_op_t op,   // Operation to perform
   input wire logic [DATA_W-1:0] opnd_a,  // Accumulator operand
   input wire logic [DATA_W-1:0] opnd_b,  // Literal or file operand
   output logic [DATA_W-1:0] result,      // Operation result
   output logic is_zero                   // Result is all zeros
);
   // One OR gate row serves both OR instructions; pass covers the moves
   always_comb
   begin
      case (op)
         oam_pkg::OAM_OP_OR:
         begin
            result = opnd_a | opnd_b;
         end
         oam_pkg::OAM_OP_PASS:
         begin
            result = opnd_b;
         end
         default:
         begin
            result = '0;
         end
      endcase
      is_zero = (result == '0);
   end
endmodule

// File: rtl/oam_exec.sv
// Decode and execute of the OR and move instructions of the core
//
// Function
// RULE1 - OR literal into accumulator, set zero flag
// RULE2 - OR accumulator with file register, set zero
// RULE3 - Destination bit: 0 accumulator, 1 file
// RULE4 - Copy file register to destination, set zero
// RULE5 - Copy to itself still updates zero flag
// RULE6 - Load literal to accumulator, flags untouched
//
// Limitation: skips and branches live elsewhere; other opcodes pass by
`timescale 1ns/1ns
module oam_exec #(
   parameter int DATA_W = 8,   // Accumulator and file width
   parameter int ADDR_W = 5    // File register address width
)(
   input wire logic clk,                           // Instruction clock
   input wire logic reset_n,                       // Asynchronous reset, active low
   input wire logic instr_valid,                   // Instruction word present this cycle
   input wire logic [oam_pkg::INSTR_W-1:0] instr,  // Instruction word
   input wire logic [DATA_W-1:0] file_rd_data,     // Data of addressed file register
   output logic [ADDR_W-1:0] file_rd_addr,         // File register read address
   output logic file_wr_en,                        // File register write pulse
   output logic [ADDR_W-1:0] file_wr_addr,         // File register write address
   output logic [DATA_W-1:0] file_wr_data,         // File register write data
   output logic [DATA_W-1:0] acc,                  // Accumulator value
   output logic zero_flag,                         // Zero status flag
   output logic zero_we,                           // Zero flag updated pulse
   output logic exec_done                          // Instruction retired pulse
);
   // Elaboration checks on the widths the decoder can serve
   // The instruction format fixes the fields, so the widths cannot grow
   if (DATA_W != oam_pkg::LIT_MSB - oam_pkg::LIT_LSB + 1)
   begin : g_bad_data
      $error("DATA_W must match the literal field width");
   end
   if (ADDR_W != oam_pkg::ADDR_MSB - oam_pkg::ADDR_LSB + 1)
   begin : g_bad_addr
      $error("ADDR_W must match the address field width");
   end

   // Stage one: instruction register, its file address drives the read port
   logic [oam_pkg::INSTR_W-1:0] ir_q, ir_d;   // Held instruction
   logic ir_vld_q, ir_vld_d;                  // Held instruction is valid

   // Stage two: architectural state and write port
   logic [DATA_W-1:0] acc_q, acc_d;           // Accumulator
   logic zero_q, zero_d;                      // Zero flag
   logic zero_we_q, zero_we_d;                // Zero update pulse
   logic wr_en_q, wr_en_d;                    // File write strobe
   logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;   // File write address
   logic [DATA_W-1:0] wr_data_q, wr_data_d;   // File write data
   logic done_q, done_d;                      // Retire pulse

   // Decode signals
   logic [3:0] op4;                           // Upper four opcode bits
   logic [5:0] op6;                           // Upper six opcode bits
   logic [DATA_W-1:0] lit;                    // Literal field
   logic [ADDR_W-1:0] faddr;                  // File address field
   logic dest;                                // Destination select
   logic [DATA_W-1:0] fdata;                  // File operand after forwarding
   logic [DATA_W-1:0] opnd_b;                 // Second operand to datapath
   oam_pkg::oam_alu_op_t alu_op;              // Datapath operation
   logic [DATA_W-1:0] alu_res;                // Datapath result
   logic alu_zero;                            // Datapath zero detect
   logic to_acc, to_file, set_zero;           // Writeback controls

   // Field extraction from the held instruction
   always_comb
   begin
      op4 = ir_q[oam_pkg::INSTR_W-1:oam_pkg::OP4_LSB];
      op6 = ir_q[oam_pkg::INSTR_W-1:oam_pkg::OP6_LSB];
      lit = ir_q[oam_pkg::LIT_MSB:oam_pkg::LIT_LSB];
      faddr = ir_q[oam_pkg::ADDR_MSB:oam_pkg::ADDR_LSB];
      dest = ir_q[oam_pkg::DEST_BIT];
   end

   // Forward the write still in flight, so back-to-back file use sees new data
   // The register file takes the write only at the next edge, so its read port
   // would still show the old value to an instruction that follows directly
   always_comb
   begin
      if (wr_en_q && (wr_addr_q == faddr))
      begin
         fdata = wr_data_q;
      end
      else
      begin
         fdata = file_rd_data;
      end
   end

   // Decoder: picks operation, operand and destinations
   always_comb
   begin
      alu_op = oam_pkg::OAM_OP_NONE;
      opnd_b = lit;
      to_acc = 1'b0;
      to_file = 1'b0;
      set_zero = 1'b0;
      if (ir_vld_q)
      begin
         if (op4 == oam_pkg::OP_OR_LITERAL)
         begin
            // RULE1 OR with literal
            alu_op = oam_pkg::OAM_OP_OR;
            to_acc = 1'b1;
            set_zero = 1'b1;
         end
         else if (op4 == oam_pkg::OP_LOAD_LITERAL)
         begin
            // RULE6 literal load, no flags
            alu_op = oam_pkg::OAM_OP_PASS;
            to_acc = 1'b1;
         end
         else if (op6 == oam_pkg::OP_OR_FILE)
         begin
            // RULE2 OR with file
            alu_op = oam_pkg::OAM_OP_OR;
            opnd_b = fdata;
            set_zero = 1'b1;
            // RULE3 destination bit select
            to_acc = (dest == oam_pkg::DEST_ACC);
            to_file = (dest == oam_pkg::DEST_FILE);
         end
         else if (op6 == oam_pkg::OP_COPY_FILE)
         begin
            // RULE4 copy file register
            alu_op = oam_pkg::OAM_OP_PASS;
            opnd_b = fdata;
            // RULE5 zero updated even on self-copy
            set_zero = 1'b1;
            // RULE3 destination bit select
            to_acc = (dest == oam_pkg::DEST_ACC);
            to_file = (dest == oam_pkg::DEST_FILE);
         end
         else
         begin
            // Opcodes of other units leave all state here alone
            alu_op = oam_pkg::OAM_OP_NONE;
         end
      end
   end

   // Shared datapath
   oam_alu #(
      .DATA_W(DATA_W)
   ) u_alu (
      .op(alu_op),
      .opnd_a(acc_q),
      .opnd_b(opnd_b),
      .result(alu_res),
      .is_zero(alu_zero)
   );

   // Next values of both stages; unknown opcodes retire nothing and change nothing
   always_comb
   begin
      ir_d = instr;
      ir_vld_d = instr_valid;
      acc_d = acc_q;
      zero_d = zero_q;
      // RULE1 single-cycle writeback
      zero_we_d = set_zero;
      wr_en_d = to_file;
      wr_addr_d = faddr;
      wr_data_d = alu_res;
      done_d = (alu_op != oam_pkg::OAM_OP_NONE);
      // Accumulator takes the result only when the decoder routes it there
      if (to_acc)
      begin
         acc_d = alu_res;
      end
      // Literal load leaves the flag alone, so only flagged operations update it
      if (set_zero)
      begin
         zero_d = alu_zero;
      end
   end

   // State registers
   // Trade-off: the fetch register costs a cycle of latency but keeps every
   // output a flop, which the rest of the core can sample without margin worries
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ir_q <= '0;
         ir_vld_q <= 1'b0;
         acc_q <= oam_pkg::ACC_RESET;
         zero_q <= oam_pkg::ZERO_RESET;
         zero_we_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         ir_q <= ir_d;
         ir_vld_q <= ir_vld_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
         zero_we_q <= zero_we_d;
         wr_en_q <= wr_en_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         done_q <= done_d;
      end
   end

   // Outputs all come from flip-flops
   // Read address comes straight from the instruction register, so the file
   // has a whole cycle to answer before the execute edge
   assign file_rd_addr = ir_q[oam_pkg::ADDR_MSB:oam_pkg::ADDR_LSB];
   assign file_wr_en = wr_en_q;
   assign file_wr_addr = wr_addr_q;
   assign file_wr_data = wr_data_q;
   assign acc = acc_q;
   assign zero_flag = zero_q;
   assign zero_we = zero_we_q;
   assign exec_done = done_q;
endmodule

// File: rtl/oam_pkg.sv
// Shared constants for the OR and move instruction execute block
package oam_pkg;
   // Instruction word layout
   localparam int INSTR_W = 12;        // Full instruction width
   localparam int LIT_LSB = 0;         // Literal field low bit
   localparam int LIT_MSB = 7;         // Literal field high bit
   localparam int ADDR_LSB = 0;        // File address field low bit
   localparam int ADDR_MSB = 4;        // File address field high bit
   localparam int DEST_BIT = 5;        // Destination select bit
   localparam int OP4_LSB = 8;         // Four-bit opcode field low bit
   localparam int OP6_LSB = 6;         // Six-bit opcode field low bit

   // Opcode patterns
   localparam logic [3:0] OP_OR_LITERAL = 4'hd;   // or_literal_into_accumulator
   localparam logic [3:0] OP_LOAD_LITERAL = 4'hc; // load_literal_to_accumulator
   localparam logic [5:0] OP_OR_FILE = 6'h04;     // or_accumulator_with_file
   localparam logic [5:0] OP_COPY_FILE = 6'h08;   // copy_file_register

   // Destination select encoding
   localparam logic DEST_ACC = 1'b0;   // Result to accumulator
   localparam logic DEST_FILE = 1'b1;  // Result back to file register

   // Reset values
   localparam logic [7:0] ACC_RESET = 8'h00;   // Accumulator after reset
   localparam logic ZERO_RESET = 1'b0;         // Zero flag after reset

   // Operation chosen by the decoder
   typedef enum logic [1:0]
   {
      OAM_OP_NONE,
      OAM_OP_OR,
      OAM_OP_PASS
   } oam_alu_op_t;
endpackage

// File: tb/oam_exec_props.sv
// Assertion checker for the OR and move execute block
`timescale 1ns/1ns
module oam_exec_props #(
   parameter int DATA_W = 8,   // Data width
   parameter int ADDR_W = 5    // File address width
)(
   input wire logic clk,                     // Clock
   input wire logic reset_n,                 // Reset, active low
   input wire logic instr_valid,             // Instruction present
   input wire logic [11:0] instr,            // Instruction word
   input wire logic [DATA_W-1:0] file_rd_data, // File read data
   input wire logic [ADDR_W-1:0] file_rd_addr, // File read address
   input wire logic file_wr_en,              // File write pulse
   input wire logic [ADDR_W-1:0] file_wr_addr, // File write address
   input wire logic [DATA_W-1:0] file_wr_data, // File write data
   input wire logic [DATA_W-1:0] acc,        // Accumulator
   input wire logic zero_flag,               // Zero flag
   input wire logic zero_we,                 // Zero update pulse
   input wire logic exec_done                // Retire pulse
);
   logic [3:0] op4;   // Literal opcode field
   logic [5:0] op6;   // File opcode field
   logic fd;          // Destination bit
   logic [DATA_W-1:0] f_eff;   // File operand once a write in flight is seen
   assign op4 = instr[11:8];
   assign op6 = instr[11:6];
   assign fd = instr[5];
   // A write still in flight reaches the next reader of the same register
   assign f_eff = (file_wr_en && file_wr_addr == file_rd_addr) ? file_wr_data : file_rd_data;
   // One clock and one reset, so declare both once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   or_lit_a: assert property (instr_valid && op4 == 4'hd |-> ##2
      acc == ($past(acc) | $past(instr[7:0], 2)) && zero_we && zero_flag == (acc == '0))
      else $error("literal or wrong");
   load_lit_a: assert property (instr_valid && op4 == 4'hc |-> ##2
      acc == $past(instr[7:0], 2) && !zero_we && $stable(zero_flag) && exec_done)
      else $error("literal load wrong");
   rd_addr_a: assert property (instr_valid && (op6 == 6'h04 || op6 == 6'h08) |=>
      file_rd_addr == $past(instr[4:0])) else $error("read address wrong");
   or_to_acc_a: assert property (instr_valid && op6 == 6'h04 && !fd |-> ##2
      acc == ($past(acc) | $past(f_eff)) && !file_wr_en && zero_we
      && zero_flag == (acc == '0)) else $error("file or to acc wrong");
   or_to_file_a: assert property (instr_valid && op6 == 6'h04 && fd |-> ##2
      file_wr_en && file_wr_addr == $past(instr[4:0], 2) && $stable(acc)
      && file_wr_data == ($past(acc) | $past(f_eff))) else $error("file or wrong");
   copy_acc_a: assert property (instr_valid && op6 == 6'h08 && !fd |-> ##2
      acc == $past(f_eff) && zero_we && zero_flag == (acc == '0))
      else $error("copy to acc wrong");
   copy_self_a: assert property (instr_valid && op6 == 6'h08 && fd |-> ##2
      file_wr_en && file_wr_data == $past(f_eff) && zero_we
      && zero_flag == (file_wr_data == '0)) else $error("copy to file wrong");
   // Unknown opcodes leave everything alone
   refused_a: assert property (instr_valid && !(op4 == 4'hd || op4 == 4'hc
      || op6 == 6'h04 || op6 == 6'h08) |-> ##2 !exec_done && !file_wr_en && $stable(acc))
      else $error("unknown opcode acted");
endmodule

bind oam_exec oam_exec_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_oam_exec_props (
   .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
   .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr), .file_wr_en(file_wr_en),
   .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .acc(acc),
   .zero_flag(zero_flag), .zero_we(zero_we), .exec_done(exec_done));

// File: tb/oam_exec_tb.sv
// Self-checking bench for the OR and move execute block
`timescale 1ns/1ns
module oam_exec_tb;
   logic clk = 1'b0;            // Instruction clock
   logic reset_n = 1'b0;        // Reset, active low
   logic instr_valid = 1'b0;    // Instruction present
   logic [11:0] instr = 12'h000; // Instruction word
   logic [7:0] file_rd_data, file_wr_data, acc;
   logic [4:0] file_rd_addr, file_wr_addr;
   logic file_wr_en, zero_flag, zero_we, exec_done;
   logic [7:0] mem [32];        // File register model
   logic [11:0] st;             // Accumulator, zero, zero_we, write, done
   int err_total = 0;
   int checks_done = 0;
   oam_exec u_oam_exec (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr(instr), .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr),
      .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
      .acc(acc), .zero_flag(zero_flag), .zero_we(zero_we), .exec_done(exec_done));
   assign st = {acc, zero_flag, zero_we, file_wr_en, exec_done};
   // Plain read port: a write lands one edge late, so the block must forward
   assign file_rd_data = mem[file_rd_addr];
   // File register write port
   always @(posedge clk)
   begin
      if (file_wr_en)
         mem[file_wr_addr] <= file_wr_data;
   end
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // Issue one word and look just after its result edge
   task automatic run(logic [11:0] w);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= w;
      @(posedge clk);
      instr_valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic t_literal();
      run(12'hc9a);
      check("load", st, {8'h9a, 4'b0001});
      run(12'hd35);
      check("or lit", st, {8'hbf, 4'b0101});
      run(12'hc00);
      run(12'hd00);
      check("or lit zero", st, {8'h00, 4'b1101});
      run(12'hc5a);
      check("load keeps zero", st, {8'h5a, 4'b1001});
   endtask
   task automatic t_or_file();
      run(12'hc91);
      run({6'h04, 1'b0, 5'd19});
      check("or file acc", st, {8'h93, 4'b0101});
      run(12'hc01);
      run({6'h04, 1'b1, 5'd5});
      check("or file wr", st, {8'h01, 4'b0111});
      @(posedge clk);
      #1;
      check("file 5", mem[5], 12'h041);
   endtask
   task automatic t_copy();
      run({6'h08, 1'b0, 5'd31});
      check("copy acc", st, {8'h00, 4'b1101});
      run({6'h08, 1'b1, 5'd7});
      check("copy self", st, {8'h00, 4'b0111});
      check("copy data", file_wr_data, 12'h080);
   endtask
   task automatic t_refused();
      run(12'h800);
      check("unknown op", st, 12'h000);
      run(12'h2a5);
      check("unknown op", st, 12'h000);
   endtask
   task automatic t_b2b();
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= 12'hc0f;
      @(posedge clk);
      instr <= 12'hdf0;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      check("first of pair", st, {8'h0f, 4'b0001});
      @(posedge clk);
      #1;
      check("second of pair", st, {8'hff, 4'b0101});
   endtask
   // Write a register and read it straight back in the next cycle
   task automatic t_fwd();
      run(12'hc02);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= {6'h04, 1'b1, 5'd7};
      @(posedge clk);
      instr <= {6'h08, 1'b0, 5'd7};
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      check("or into file 7", st, {8'h02, 4'b0111});
      check("file 7 data", file_wr_data, 12'h082);
      @(posedge clk);
      #1;
      check("copy fresh file 7", st, {8'h82, 4'b0101});
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
      mem[19] = 8'h13;
      mem[5] = 8'h40;
      mem[7] = 8'h80;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      check("reset", st, 12'h000);
      t_literal();
      t_or_file();
      t_copy();
      t_refused();
      t_b2b();
      t_fwd();
      conclude();
   end
   // Hang guard
   initial
   begin
      #100000;
      err_total++;
      conclude();
   end
endmodule
